/* tpio_defines.vh */
// Constants for the three-port parallel I/O block.
// Assumes a 32-bit AHB-Lite slave with byte addresses four times the register index.
`ifndef TPIO_DEFINES_VH
`define TPIO_DEFINES_VH

// ****************************************
// Register indexes and word addresses
// ****************************************
`define TPIO_IDX_A_DATA 8'h00
`define TPIO_IDX_B_DATA 8'h01
`define TPIO_IDX_C_DATA 8'h02
`define TPIO_IDX_A_DIR 8'h04
`define TPIO_IDX_B_DIR 8'h05
`define TPIO_IDX_C_DIR 8'h06
`define TPIO_IDX_ADC_SEL 8'h10

// ****************************************
// Fields and reset values
// ****************************************
`define TPIO_CLKOUT_BIT 7
`define TPIO_CLK_PIN 2
`define TPIO_DIR_RESET 8'h00
`define TPIO_SEL_RESET 5'h1F
`define TPIO_C_MASK_64 6'h3F
`define TPIO_C_MASK_52 6'h1F

`endif

/* tpio_ports.v */
// Ports A, B and C: data latches, direction registers, pin muxing, AHB-Lite slave.
// Assumes pins are synchronous to hclk; pad logic resolves the enables.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "tpio_defines.vh"

// ****************************************
// Behaviour
// - Port A: eight latch and direction bits
// - Port C six bits, top pin optional
// - Direction one drives pin, zero floats
// - Reset clears direction registers A, B, C
// - Direction registers A, B read back last write; C bit 6 reads zero
// - Reset leaves data latches unchanged
// - Data read: latch if output, else pin
// - Latch writes always accepted
// - Input pin write touches latch only
// - Channel select makes port B pin analog
// - Analog pin read: zero or latch
// - Analog pin ignores direction for drive
// - Direction C bit 7 drives clock out
// - Clock out overrides pin direction bit
// - Reset clears clock-output enable
// - Unimplemented port C bits read zero
// - Direction B at 5, C at 6
// ****************************************

module tpio_ports #(
  parameter PKG_64PIN = 1,
  parameter CH_COUNT = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire sysclk_in,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  input wire [7:0] first_port_pins_in,
  output wire [7:0] first_port_pins_out,
  output wire [7:0] first_port_pins_oe,
  input wire [7:0] second_port_pins_in,
  output wire [7:0] second_port_pins_out,
  output wire [7:0] second_port_pins_oe,
  output wire [7:0] analog_channel_pins,
  input wire [5:0] third_port_pins_in,
  output wire [5:0] third_port_pins_out,
  output wire [5:0] third_port_pins_oe
);

  // ****************************************
  // State
  // ****************************************
  // Latches have no reset on purpose: their value must survive system reset.
  reg [7:0] first_port_latch;
  reg [7:0] second_port_latch;
  reg [5:0] third_port_latch;
  reg [7:0] first_port_direction_q;
  reg [7:0] second_port_direction_q;
  reg [5:0] third_port_direction_q;
  reg sysclk_out_enable_q;
  reg [4:0] converter_channel_select_q;
  reg wr_pend_q;
  reg [7:0] wr_idx_q;
  wire [5:0] c_mask;
  wire [7:0] adc_use;
  wire addr_ok;
  wire [7:0] rd_idx;
  wire [7:0] c_read;
  reg [7:0] rd_byte;

  assign c_mask = (PKG_64PIN != 0) ? `TPIO_C_MASK_64 : `TPIO_C_MASK_52;

  // One-hot channel decode; selects past the port B range pick no pin.
  function [7:0] chan_decode;
    input [4:0] sel;
    begin
      chan_decode = (sel < CH_COUNT) ? (8'h01 << sel[2:0]) : 8'h00;
    end
  endfunction

  // Per bit: latch when output, else pin level.
  function [7:0] port_read;
    input [7:0] dir;
    input [7:0] latch;
    input [7:0] pin;
    begin
      port_read = (dir & latch) | (~dir & pin);
    end
  endfunction

  assign adc_use = chan_decode(converter_channel_select_q);

  // ****************************************
  // Bus slave
  // ****************************************
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel && htrans[1] && hready && (haddr[1:0] == 2'b00) && (haddr[31:10] == 22'h0);
  assign rd_idx = haddr[9:2];
  assign c_read = port_read({2'b00, third_port_direction_q}, {2'b00, third_port_latch}, {2'b00, third_port_pins_in});

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
      hrdata <= 32'h00000000;
    end else if (clk_en) begin
      wr_pend_q <= addr_ok && hwrite;
      wr_idx_q <= rd_idx;
      // Pins sampled at the read's address edge, returned in the data phase
      hrdata <= (addr_ok && !hwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end
  end

  always @* begin
    case (rd_idx)
      `TPIO_IDX_A_DATA: rd_byte = port_read(first_port_direction_q, first_port_latch, first_port_pins_in);
      // Analog pins read zero as input, latch as output
      `TPIO_IDX_B_DATA: rd_byte = port_read(second_port_direction_q, second_port_latch,
                                  second_port_pins_in & ~adc_use);
      `TPIO_IDX_C_DATA: rd_byte = {2'b00, c_mask & c_read[5:0]};
      `TPIO_IDX_A_DIR: rd_byte = first_port_direction_q;
      `TPIO_IDX_B_DIR: rd_byte = second_port_direction_q;
      `TPIO_IDX_C_DIR: rd_byte = {sysclk_out_enable_q, 1'b0, third_port_direction_q & c_mask};
      `TPIO_IDX_ADC_SEL: rd_byte = {3'b000, converter_channel_select_q};
      default: rd_byte = 8'h00;
    endcase
  end

  // ****************************************
  // Data latches
  // ****************************************
  always @(posedge hclk) begin
    if (clk_en && wr_pend_q) begin
      // Accepted whatever the direction bit says
      if (wr_idx_q == `TPIO_IDX_A_DATA) begin
        first_port_latch <= hwdata[7:0];
      end
      if (wr_idx_q == `TPIO_IDX_B_DATA) begin
        second_port_latch <= hwdata[7:0];
      end
      if (wr_idx_q == `TPIO_IDX_C_DATA) begin
        third_port_latch <= hwdata[5:0] & c_mask;
      end
    end
  end

  // ****************************************
  // Direction registers
  // ****************************************
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_port_direction_q <= `TPIO_DIR_RESET;
      second_port_direction_q <= `TPIO_DIR_RESET;
      third_port_direction_q <= 6'h00;
      sysclk_out_enable_q <= 1'b0;
      converter_channel_select_q <= `TPIO_SEL_RESET;
    end else if (clk_en && wr_pend_q) begin
      if (wr_idx_q == `TPIO_IDX_A_DIR) begin
        first_port_direction_q <= hwdata[7:0];
      end
      if (wr_idx_q == `TPIO_IDX_B_DIR) begin
        second_port_direction_q <= hwdata[7:0];
      end
      if (wr_idx_q == `TPIO_IDX_C_DIR) begin
        third_port_direction_q <= hwdata[5:0] & c_mask;
        sysclk_out_enable_q <= hwdata[`TPIO_CLKOUT_BIT];
      end
      if (wr_idx_q == `TPIO_IDX_ADC_SEL) begin
        converter_channel_select_q <= hwdata[4:0];
      end
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  assign first_port_pins_out = first_port_latch;
  assign first_port_pins_oe = first_port_direction_q;
  assign second_port_pins_out = second_port_latch;
  assign second_port_pins_oe = second_port_direction_q & ~adc_use;
  assign analog_channel_pins = adc_use;

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_c_pin
      if (gi == `TPIO_CLK_PIN) begin : g_clk
        // Clock gated by a register bit; glitch-free only if enable changes while clock is low.
        assign third_port_pins_out[gi] = sysclk_out_enable_q ? sysclk_in : third_port_latch[gi];
        assign third_port_pins_oe[gi] = sysclk_out_enable_q | third_port_direction_q[gi];
      end else begin : g_io
        assign third_port_pins_out[gi] = third_port_latch[gi];
        assign third_port_pins_oe[gi] = third_port_direction_q[gi] & c_mask[gi];
      end
    end
  endgenerate

endmodule // tpio_ports

/* tpio_pins.sv */
// Pin model: a pad driven by the port, else held by the outside level.
// Assumes the bench supplies the outside level of each pin.
`timescale 1ns/1ps
module tpio_pins #(
  parameter W = 8
) (
  input wire [W-1:0] out,
  input wire [W-1:0] oe,
  input wire [W-1:0] ext,
  output wire [W-1:0] lvl
);
  // Undriven pads take the outside level, never the last driven one
  assign lvl = (oe & out) | (~oe & ext);
endmodule // tpio_pins

/* tpio_ports_props.sv */
// Port checker for tpio_ports.
// Assumes hready follows hreadyout; transfers count only while clk_en is high.
`timescale 1ns/1ps
module tpio_props (
  input wire hclk,
  input wire hresetn,
  input wire clk_en,
  input wire sysclk_in,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire [7:0] first_port_pins_in,
  input wire [7:0] first_port_pins_out,
  input wire [7:0] first_port_pins_oe,
  input wire [7:0] second_port_pins_oe,
  input wire [7:0] analog_channel_pins,
  input wire [5:0] third_port_pins_out,
  input wire [5:0] third_port_pins_oe
);
  wire tk = hsel && htrans[1] && hreadyout && clk_en;
  wire [7:0] a_rd = first_port_pins_oe & first_port_pins_out | ~first_port_pins_oe & first_port_pins_in;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rst_oe_a: assert property ($rose(hresetn) |->
    {first_port_pins_oe, second_port_pins_oe, third_port_pins_oe} == 22'h0) else $error("driven after reset");
  an_oe_a: assert property ((second_port_pins_oe & analog_channel_pins) == 8'h00)
    else $error("analog pin driven");
  a_dir_a: assert property (tk && hwrite && haddr == 32'h10 ##1 1 |=>
    first_port_pins_oe == $past(hwdata[7:0])) else $error("dir A wrong");
  a_latch_a: assert property (tk && hwrite && haddr == 32'h0 ##1 1 |=>
    first_port_pins_out == $past(hwdata[7:0])) else $error("latch A wrong");
  b_dir_a: assert property (tk && hwrite && haddr == 32'h14 ##1 1 |=>
    second_port_pins_oe == ($past(hwdata[7:0]) & ~analog_channel_pins)) else $error("dir B wrong");
  clk_out_a: assert property (tk && hwrite && haddr == 32'h18 ##1 hwdata[7] |=>
    third_port_pins_oe[2] && third_port_pins_out[2] == sysclk_in) else $error("clock out off");
  c_unimp_a: assert property (tk && !hwrite && haddr == 32'h8 |=> hrdata[31:6] == 26'h0)
    else $error("C top bits set");
  a_read_a: assert property (tk && !hwrite && haddr == 32'h0 |=> hrdata[7:0] == $past(a_rd))
    else $error("read A wrong");
endmodule // tpio_props
bind tpio_ports tpio_props u_props (.*);

/* three_port_parallel_io_test.sv */
// Bench for tpio_ports over AHB-Lite.
// Assumes pins are modelled by tpio_pins with outside levels set by the bench.
`timescale 1ns/1ps
`define CK(a, e) begin check_count++; if ((a) !== (e)) begin err_count++; $display("Error %0t %h %h", $time, a, e); end end
module three_port_parallel_io_test;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, sk = 0, hresp, hreadyout;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [7:0] ao, ae, ai, bo, be, bi, an, r;
  logic [5:0] co, ce, ci;
  logic [7:0] ea = 8'h5A, eb = 8'h99;
  logic [5:0] ec = 6'h15;
  logic en = 1'b1;
  int err_count = 0, check_count = 0;
  always #5 hclk = ~hclk;
  // Period chosen so its edges never meet a sampling point
  always #8 sk = ~sk;
  tpio_ports DUT (.hclk(hclk), .hresetn(hresetn), .clk_en(en), .sysclk_in(sk), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .first_port_pins_in(ai), .first_port_pins_out(ao),
    .first_port_pins_oe(ae), .second_port_pins_in(bi), .second_port_pins_out(bo), .second_port_pins_oe(be),
    .analog_channel_pins(an), .third_port_pins_in(ci), .third_port_pins_out(co), .third_port_pins_oe(ce));
  tpio_pins #(.W(8)) pa (.out(ao), .oe(ae), .ext(ea), .lvl(ai));
  tpio_pins #(.W(8)) pb (.out(bo), .oe(be), .ext(eb), .lvl(bi));
  tpio_pins #(.W(6)) pc (.out(co), .oe(ce), .ext(ec), .lvl(ci));
  task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= a;
    @(posedge hclk); while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0; hwdata <= {24'h0, d};
    @(posedge hclk); while (!hreadyout) @(posedge hclk);
    r = hrdata[7:0];
    `CK(hresp, 1'b0)
    #1;
  endtask
  task wr(input logic [31:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [31:0] a, input logic [7:0] e);
    xfer(1'b0, a, 8'h00);
    `CK(r, e)
  endtask
  task t_reset;
    `CK({ae, be, ce}, 22'h0)
    rd(32'h10, 8'h00);
    rd(32'h14, 8'h00);
    rd(32'h18, 8'h00);
    rd(32'h3C, 8'h00);
  endtask
  task t_porta;
    wr(32'h00, 8'hA5);
    rd(32'h00, 8'h5A);
    `CK(ai, 8'h5A)
    wr(32'h10, 8'h0F);
    rd(32'h10, 8'h0F);
    rd(32'h00, 8'h55);
    `CK(ai, 8'h55)
    // Frozen enable must drop the write
    en <= 1'b0;
    wr(32'h10, 8'h00);
    en <= 1'b1;
    rd(32'h10, 8'h0F);
    ea <= 8'hA3;
    rd(32'h00, 8'hA5);
  endtask
  task t_portb;
    wr(32'h04, 8'h3C);
    wr(32'h14, 8'hF0);
    wr(32'h40, 8'h03);
    `CK(an, 8'h08)
    rd(32'h04, 8'h31);
    wr(32'h14, 8'hFF);
    `CK(be, 8'hF7)
    rd(32'h04, 8'h3C);
  endtask
  task t_portc;
    wr(32'h08, 8'hFF);
    wr(32'h18, 8'hC4);
    rd(32'h18, 8'h84);
    rd(32'h08, 8'h15);
    wr(32'h18, 8'h80);
    `CK(ce, 6'h04)
    `CK(co[2], sk)
    @(posedge hclk) hresetn <= 1'b0;
    @(posedge hclk) hresetn <= 1'b1;
    rd(32'h18, 8'h00);
    wr(32'h10, 8'hFF);
    rd(32'h00, 8'hA5);
  endtask
  task summarize;
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_porta;
    t_portb;
    t_portc;
    summarize;
  end
  initial begin
    #5000;
    err_count++;
    summarize;
  end
endmodule // three_port_parallel_io_test
